// *** include/comm_dict_pkg.sv ***
// Constants, codes and field layout of the communication-profile dictionary
package comm_dict_pkg;
	// Object indices
	localparam logic [15:0] IDX_DEVTYPE = 16'h1000;
	localparam logic [15:0] IDX_ERRREG = 16'h1001;
	localparam logic [15:0] IDX_ERRHIST = 16'h1003;
	localparam logic [15:0] IDX_SYNC = 16'h1005;
	localparam logic [15:0] IDX_NAME = 16'h1008;
	localparam logic [15:0] IDX_HWVER = 16'h1009;
	localparam logic [15:0] IDX_SWVER = 16'h100A;
	localparam logic [15:0] IDX_GUARD = 16'h100C;
	localparam logic [15:0] IDX_LIFE = 16'h100D;
	localparam logic [15:0] IDX_STORE = 16'h1010;
	localparam logic [15:0] IDX_RESTORE = 16'h1011;
	localparam logic [15:0] IDX_EMCY = 16'h1014;
	localparam logic [15:0] IDX_INHIBIT = 16'h1015;
	localparam logic [15:0] IDX_IDENT = 16'h1018;
	localparam logic [15:0] IDX_SDO = 16'h1200;
	// Sub-index limits and answers
	localparam logic [7:0] SUB_ZERO = 8'h00;
	localparam logic [7:0] SUB_ONE = 8'h01;
	localparam logic [7:0] SUB_TWO = 8'h02;
	localparam logic [7:0] SUB_STORE_MAX = 8'h03;
	localparam logic [7:0] SUB_HIST_MAX = 8'h05;
	localparam logic [31:0] STORE_COUNT = 32'h0000_0003;
	localparam logic [31:0] IDENT_COUNT = 32'h0000_0001;
	localparam logic [31:0] SDO_COUNT = 32'h0000_0002;
	localparam logic [31:0] STORE_CAPS = 32'h0000_0001;
	// Field layout and reset values
	localparam logic [15:0] PROFILE_NUM = 16'h0191;
	localparam logic [7:0] SPECIFIC_FUNC = 8'h00;
	localparam logic [3:0] IO_UPPER_ZERO = 4'h0;
	localparam int SYNC_ID_W = 11;
	localparam logic [31:0] SYNC_RESET = 32'h0000_0080;
	localparam logic [31:0] EMCY_BASE = 32'h0000_0080;
	localparam logic [31:0] RX_SDO_BASE = 32'h0000_0600;
	localparam logic [31:0] TX_SDO_BASE = 32'h0000_0580;
	localparam logic [15:0] TIME_MAX = 16'h7FFF;
	localparam int HIST_DEPTH = 5;
	// Abort codes
	localparam logic [31:0] ABORT_NONE = 32'h0000_0000;
	localparam logic [31:0] ABORT_NO_OBJ = 32'h0602_0000;
	localparam logic [31:0] ABORT_NO_SUB = 32'h0609_0011;
	localparam logic [31:0] ABORT_READ_ONLY = 32'h0601_0002;
	localparam logic [31:0] ABORT_RANGE = 32'h0609_0030;
	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
endpackage

// *** include/dict_side_if.sv ***
// Carrier between the dictionary and its history and emergency-pacing helpers
`timescale 1ns/1ns
interface dict_side_if;
	logic err_push;
	logic [31:0] err_code;
	logic [2:0] hist_sel;
	logic [31:0] hist_data;
	logic [2:0] hist_count;
	logic [15:0] inhibit_ms;
	logic emcy_req;
	logic emcy_go;
	modport hist (input err_push, err_code, hist_sel, output hist_data, hist_count);
	modport pace (input inhibit_ms, emcy_req, output emcy_go);
	modport ctrl (output err_push, err_code, hist_sel, inhibit_ms, emcy_req,
		input hist_data, hist_count, emcy_go);
endinterface

// *** hw/err_history.sv ***
// Five-deep error history, newest entry first
`timescale 1ns/1ns
module err_history
	import comm_dict_pkg::*;
#(
	parameter int DEPTH = comm_dict_pkg::HIST_DEPTH
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Dictionary side
	dict_side_if.hist side
);
	logic [31:0] entry_r [DEPTH];
	logic [2:0] count_r;

	// shift older entries down on each new error
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				entry_r[i] <= '0;
			end
		end else if (side.err_push) begin
			entry_r[0] <= side.err_code;
			for (int i = 1; i < DEPTH; i++) begin
				entry_r[i] <= entry_r[i-1];
			end
		end
	end

	// count saturates at depth; oldest falls off the end
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			count_r <= '0;
		end else if (side.err_push && count_r != 3'(DEPTH)) begin
			count_r <= count_r + 3'd1;
		end
	end

	// Selector 1 is newest; out-of-range selects read zero, caller aborts them
	always_comb begin
		side.hist_data = '0;
		for (int i = 0; i < DEPTH; i++) begin
			if (side.hist_sel == 3'(i + 1)) begin
				side.hist_data = entry_r[i];
			end
		end
	end
	assign side.hist_count = count_r;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	a_hist_count_max: assert property (count_r <= 3'(DEPTH)) else $error("history count above depth");
	a_hist_newest: assert property (side.err_push |=> entry_r[0] == $past(side.err_code))
		else $error("newest history entry not the last pushed code");
	c_hist_full: cover property (count_r == 3'(DEPTH) && side.err_push);
endmodule

// *** hw/emcy_pacer.sv ***
// Paces emergency messages so the inhibit time in ms separates them
`timescale 1ns/1ns
module emcy_pacer
	import comm_dict_pkg::*;
#(
	parameter int CYC_PER_MS = comm_dict_pkg::MS_CYCLES
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Dictionary side
	dict_side_if.pace side
);
	typedef enum logic [1:0] {
		PACE_IDLE = 2'b01,
		PACE_HOLD = 2'b10
	} pace_e;
	pace_e state_r;
	logic [31:0] presc_r;
	logic [15:0] ms_left_r;
	logic ms_tick;

	assign ms_tick = (presc_r == 32'(CYC_PER_MS - 1));
	// Request passes only while no hold is running
	assign side.emcy_go = side.emcy_req && state_r == PACE_IDLE;

	// hold for the inhibit time after each message, zero means no hold
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_r <= PACE_IDLE;
			ms_left_r <= '0;
		end else begin
			unique case (state_r)
				PACE_IDLE: begin
					if (side.emcy_go && side.inhibit_ms != '0) begin
						state_r <= PACE_HOLD;
						ms_left_r <= side.inhibit_ms;
					end
				end
				PACE_HOLD: begin
					if (ms_tick) begin
						ms_left_r <= ms_left_r - 16'd1;
						if (ms_left_r == 16'd1) begin
							state_r <= PACE_IDLE;
						end
					end
				end
				default: state_r <= PACE_IDLE;
			endcase
		end
	end

	// Millisecond prescaler, restarted at each message so the hold is never short
	always_ff @(posedge mclk_in) begin
		if (rst_in || side.emcy_go || ms_tick) begin
			presc_r <= '0;
		end else begin
			presc_r <= presc_r + 32'd1;
		end
	end

	// Helper: cycles since last message and the hold it asked for
	logic [47:0] since_r;
	logic [15:0] last_inh_r;
	logic seen_r;
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			since_r <= '0;
			last_inh_r <= '0;
			seen_r <= 1'b0;
		end else if (side.emcy_go) begin
			since_r <= 48'd1;
			last_inh_r <= side.inhibit_ms;
			seen_r <= 1'b1;
		end else if (since_r != '1) begin
			since_r <= since_r + 48'd1;
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	a_emcy_gap: assert property (side.emcy_go && seen_r |-> since_r >= 48'(last_inh_r) * 48'(CYC_PER_MS))
		else $error("emergency messages closer than inhibit time");
	a_emcy_zero_inh: assert property (side.emcy_go && side.inhibit_ms == '0 |=> state_r == PACE_IDLE)
		else $error("zero inhibit time started a hold");
	c_emcy_twice: cover property (side.emcy_go && seen_r && last_inh_r != '0);
endmodule

// *** hw/comm_dictionary.sv ***
// Communication-profile dictionary of the slave, reached by index and sub-index
`timescale 1ns/1ns
module comm_dictionary
	import comm_dict_pkg::*;
#(
	parameter logic [3:0] IO_CAPS = 4'h0,
	parameter logic [31:0] NAME_STR = 32'h4e4f_4445,
	parameter logic [31:0] HW_VER_STR = 32'h4857_3031,
	parameter logic [31:0] SW_VER_STR = 32'h5357_3031,
	// Arbitrary vendor code, replace with the assigned one
	parameter logic [31:0] VENDOR_CODE = 32'h0000_0000,
	parameter int CYC_PER_MS = comm_dict_pkg::MS_CYCLES
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Node configuration
	input wire logic [6:0] node_id_in,
	// SDO request
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire logic [15:0] req_index_in,
	input wire logic [7:0] req_subidx_in,
	input wire logic [31:0] req_wdata_in,
	// SDO answer
	output logic rsp_valid_out,
	output logic rsp_abort_out,
	output logic [31:0] rsp_data_out,
	// Error reporting
	input wire logic [7:0] error_reg_in,
	input wire logic err_push_in,
	input wire logic [31:0] err_code_in,
	input wire logic emcy_req_in,
	output logic emcy_send_out,
	// Received frame identifiers
	input wire logic rx_valid_in,
	input wire logic [10:0] rx_id_in,
	output logic sync_seen_out,
	// Parameter storage commands
	output logic store_cmd_out,
	output logic restore_cmd_out,
	output logic [1:0] store_group_out,
	// Live settings
	output logic [31:0] sync_id_out,
	output logic [31:0] emcy_id_out,
	output logic [15:0] guard_time_out,
	output logic [7:0] life_factor_out
);
	dict_side_if side ();

	logic [10:0] sync_id_r;
	logic [31:0] emcy_id_r;
	logic [15:0] guard_r;
	logic [7:0] life_r;
	logic [15:0] inhibit_r;
	logic [31:0] devtype;
	logic [31:0] node32;
	logic [31:0] rd_nxt;
	logic [31:0] code_nxt;
	logic wr_ok;

	err_history #(.DEPTH(HIST_DEPTH)) u_hist (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.side(side.hist)
	);
	emcy_pacer #(.CYC_PER_MS(CYC_PER_MS)) u_pace (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.side(side.pace)
	);

	// fixed device type, specific byte held at zero
	assign devtype = {SPECIFIC_FUNC, IO_UPPER_ZERO, IO_CAPS, PROFILE_NUM};
	// SDO identifiers follow the live node id, so a renumbered node moves at once
	assign node32 = {25'h000_0000, node_id_in};

	// Helper wiring
	assign side.err_push = err_push_in;
	assign side.err_code = err_code_in;
	// Selector follows the live sub-index so the word is ready at the answer edge
	assign side.hist_sel = req_subidx_in[2:0];
	assign side.inhibit_ms = inhibit_r;
	assign side.emcy_req = emcy_req_in;
	assign emcy_send_out = side.emcy_go;

	// decode one request: read data or abort code
	always_comb begin
		rd_nxt = '0;
		code_nxt = ABORT_NONE;
		unique case (req_index_in)
			IDX_DEVTYPE, IDX_ERRREG, IDX_NAME, IDX_HWVER, IDX_SWVER: begin
				if (req_subidx_in != SUB_ZERO) begin
					code_nxt = ABORT_NO_SUB;
				end else if (req_write_in) begin
					code_nxt = ABORT_READ_ONLY;
				end
				unique case (req_index_in)
					IDX_DEVTYPE: rd_nxt = devtype;
					IDX_ERRREG: rd_nxt = {24'h00_0000, error_reg_in};
					IDX_NAME: rd_nxt = NAME_STR;
					IDX_HWVER: rd_nxt = HW_VER_STR;
					default: rd_nxt = SW_VER_STR;
				endcase
			end
			IDX_ERRHIST: begin
				// sub-index 0 is the count; unfilled slots are absent
				if (req_subidx_in > SUB_HIST_MAX ||
						(req_subidx_in != SUB_ZERO && req_subidx_in[2:0] > side.hist_count)) begin
					code_nxt = ABORT_NO_SUB;
				end else if (req_write_in) begin
					code_nxt = ABORT_READ_ONLY;
				end
				rd_nxt = (req_subidx_in == SUB_ZERO) ? {29'h0, side.hist_count} : side.hist_data;
			end
			IDX_SYNC, IDX_EMCY, IDX_GUARD, IDX_LIFE, IDX_INHIBIT: begin
				if (req_subidx_in != SUB_ZERO) begin
					code_nxt = ABORT_NO_SUB;
				end else if (req_write_in && (req_index_in == IDX_GUARD || req_index_in == IDX_INHIBIT)
						&& req_wdata_in > {16'h0000, TIME_MAX}) begin
					// times above the limit are refused
					code_nxt = ABORT_RANGE;
				end
				unique case (req_index_in)
					// extended, generate and bit 31 read zero
					IDX_SYNC: rd_nxt = {21'h00_0000, sync_id_r};
					IDX_EMCY: rd_nxt = emcy_id_r;
					IDX_GUARD: rd_nxt = {16'h0000, guard_r};
					IDX_LIFE: rd_nxt = {24'h00_0000, life_r};
					default: rd_nxt = {16'h0000, inhibit_r};
				endcase
			end
			IDX_STORE, IDX_RESTORE: begin
				// sub-index 0 is the group count, 1..3 the groups
				if (req_subidx_in > SUB_STORE_MAX) begin
					code_nxt = ABORT_NO_SUB;
				end else if (req_write_in && req_subidx_in == SUB_ZERO) begin
					code_nxt = ABORT_READ_ONLY;
				end
				// Any written value triggers; with no signature check a stray write saves too
				rd_nxt = (req_subidx_in == SUB_ZERO) ? STORE_COUNT : STORE_CAPS;
			end
			IDX_IDENT: begin
				if (req_subidx_in > SUB_ONE) begin
					code_nxt = ABORT_NO_SUB;
				end else if (req_write_in) begin
					code_nxt = ABORT_READ_ONLY;
				end
				// Only the vendor code is offered; product, revision and serial are absent
				rd_nxt = (req_subidx_in == SUB_ZERO) ? IDENT_COUNT : VENDOR_CODE;
			end
			IDX_SDO: begin
				// server identifiers follow the node id, read-only
				if (req_subidx_in > SUB_TWO) begin
					code_nxt = ABORT_NO_SUB;
				end else if (req_write_in) begin
					code_nxt = ABORT_READ_ONLY;
				end
				if (req_subidx_in == SUB_ZERO) begin
					rd_nxt = SDO_COUNT;
				end else if (req_subidx_in == SUB_ONE) begin
					rd_nxt = RX_SDO_BASE + node32;
				end else begin
					rd_nxt = TX_SDO_BASE + node32;
				end
			end
			// Anything outside this profile area, PDO entries included, is absent
			default: code_nxt = ABORT_NO_OBJ;
		endcase
	end
	// A write lands only when the decode found nothing to refuse
	assign wr_ok = req_valid_in && req_write_in && code_nxt == ABORT_NONE;

	// Answer one cycle after each request; an abort carries its code as data
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			rsp_valid_out <= 1'b0;
			rsp_abort_out <= 1'b0;
			rsp_data_out <= '0;
		end else begin
			rsp_valid_out <= req_valid_in;
			rsp_abort_out <= req_valid_in && code_nxt != ABORT_NONE;
			// Data holds between answers so a slow reader still finds the last one
			if (req_valid_in) begin
				rsp_data_out <= (code_nxt != ABORT_NONE) ? code_nxt : (req_write_in ? '0 : rd_nxt);
			end
		end
	end

	// keep only the 11-bit identifier; generation never supported
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			sync_id_r <= SYNC_RESET[10:0];
		end else if (wr_ok && req_index_in == IDX_SYNC) begin
			// Upper bits are dropped here, which is why reads show them as zero
			sync_id_r <= req_wdata_in[10:0];
		end
	end

	// emergency identifier resets relative to the node id
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			// Node id is taken at reset; a later change leaves this entry alone
			emcy_id_r <= EMCY_BASE + node32;
		end else if (wr_ok && req_index_in == IDX_EMCY) begin
			emcy_id_r <= req_wdata_in;
		end
	end

	// guarding and inhibit settings, guard and inhibit ranges already checked, life factor cut to 8 bits
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			guard_r <= '0;
			life_r <= '0;
			inhibit_r <= '0;
		end else if (wr_ok) begin
			if (req_index_in == IDX_GUARD) begin
				guard_r <= req_wdata_in[15:0];
			end
			if (req_index_in == IDX_LIFE) begin
				life_r <= req_wdata_in[7:0];
			end
			if (req_index_in == IDX_INHIBIT) begin
				inhibit_r <= req_wdata_in[15:0];
			end
		end
	end

	// one-cycle store or restore command with its group
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			store_cmd_out <= 1'b0;
			restore_cmd_out <= 1'b0;
			store_group_out <= '0;
		end else begin
			store_cmd_out <= wr_ok && req_index_in == IDX_STORE;
			restore_cmd_out <= wr_ok && req_index_in == IDX_RESTORE;
			// Group holds after the pulse for a service that acts late
			if (wr_ok && (req_index_in == IDX_STORE || req_index_in == IDX_RESTORE)) begin
				store_group_out <= req_subidx_in[1:0];
			end
		end
	end

	// SYNC identifier only used to recognise received frames
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			sync_seen_out <= 1'b0;
		end else begin
			// Only 11-bit identifiers are matched; extended frames never count as SYNC
			sync_seen_out <= rx_valid_in && rx_id_in == sync_id_r;
		end
	end

	assign sync_id_out = {21'h00_0000, sync_id_r};
	assign emcy_id_out = emcy_id_r;
	assign guard_time_out = guard_r;
	assign life_factor_out = life_r;

	// Checks on the request decode, the settings and the command pulses
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	a_devtype_read: assert property (req_valid_in && !req_write_in && req_index_in == IDX_DEVTYPE &&
		req_subidx_in == SUB_ZERO |=> rsp_data_out[31:24] == 8'h00 && rsp_data_out[15:0] == PROFILE_NUM)
		else $error("device type reads wrong");
	a_sync_reset: assert property ($past(rst_in) |-> sync_id_out == SYNC_RESET) else $error("sync id reset");
	a_sync_upper: assert property (req_valid_in && req_index_in == IDX_SYNC && !req_write_in
		&& req_subidx_in == SUB_ZERO |=> rsp_data_out[31:11] == '0) else $error("sync upper bits set");
	a_guard_range: assert property (guard_time_out <= TIME_MAX) else $error("guard time out of range");
	a_emcy_reset: assert property ($past(rst_in) |-> emcy_id_out == EMCY_BASE + $past(node32))
		else $error("emergency id reset");
	a_ro_abort: assert property (req_valid_in && req_write_in && req_index_in == IDX_SDO
		|=> rsp_valid_out && rsp_abort_out) else $error("write to read-only not aborted");
	a_sdo_rx_id: assert property (req_valid_in && !req_write_in && req_index_in == IDX_SDO &&
		req_subidx_in == SUB_ONE |=> rsp_data_out == RX_SDO_BASE + $past(node32)) else $error("rx sdo id");
	a_store_pulse: assert property (wr_ok && req_index_in == IDX_STORE |=> store_cmd_out &&
		store_group_out == $past(req_subidx_in[1:0])
		##1 store_cmd_out == $past(wr_ok && req_index_in == IDX_STORE)) else $error("store command");

	// Answer framing: one answer per request, aborts always carry a code
	a_rsp_once: assert property (rsp_valid_out == $past(req_valid_in))
		else $error("answer missing or late");
	a_abort_code: assert property (rsp_abort_out |-> rsp_valid_out && rsp_data_out != ABORT_NONE)
		else $error("abort without code");
	a_write_zero: assert property (wr_ok |=> rsp_valid_out && !rsp_abort_out && rsp_data_out == '0)
		else $error("accepted write answered badly");
	// Aborted writes leave the guard, SYNC, emergency and life settings as they were
	a_abort_keeps: assert property (req_valid_in && req_write_in && code_nxt != ABORT_NONE |=>
		$stable(guard_time_out) && $stable(sync_id_out) && $stable(emcy_id_out) && $stable(life_factor_out))
		else $error("aborted write changed a setting");
	a_sync_write: assert property (wr_ok && req_index_in == IDX_SYNC |=>
		sync_id_out == {21'h00_0000, $past(req_wdata_in[10:0])}) else $error("sync write kept upper bits");
	a_sync_match: assert property (rx_valid_in && rx_id_in == sync_id_out[10:0] |=> sync_seen_out)
		else $error("sync frame not recognised");
	a_restore_pulse: assert property (wr_ok && req_index_in == IDX_RESTORE |=>
		restore_cmd_out && !store_cmd_out) else $error("restore command");
	a_inhibit_range: assert property (inhibit_r <= TIME_MAX) else $error("inhibit time out of range");
	c_store: cover property (store_cmd_out && store_group_out == 2'd3);
	c_abort: cover property (rsp_abort_out && rsp_data_out == ABORT_RANGE);
	c_sync: cover property (sync_seen_out);
endmodule

// *** test/sdo_client_model.sv ***
// SDO client model that issues one dictionary request at a time and collects the answer
`timescale 1ns/1ns
module sdo_client_model (
	// Clock
	input wire logic mclk_in,
	// Request to the dictionary
	output logic req_valid_out,
	output logic req_write_out,
	output logic [15:0] req_index_out,
	output logic [7:0] req_subidx_out,
	output logic [31:0] req_wdata_out,
	// Answer from the dictionary
	input wire logic rsp_valid_in,
	input wire logic rsp_abort_in,
	input wire logic [31:0] rsp_data_in
);
	// Idle request lines at time zero
	initial begin
		req_valid_out = 1'b0;
		req_write_out = 1'b0;
		req_index_out = 16'h0000;
		req_subidx_out = 8'h00;
		req_wdata_out = 32'h0000_0000;
	end

	task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] wd, output logic [31:0] rd, output logic ab);
		int n;
		n = 0;
		@(posedge mclk_in);
		req_valid_out <= 1'b1;
		req_write_out <= wr;
		req_index_out <= idx;
		req_subidx_out <= sub;
		req_wdata_out <= wd;
		@(posedge mclk_in);
		// Released fields turn to their inverse so a stale word never passes for a live one
		req_valid_out <= 1'b0;
		req_write_out <= ~wr;
		req_index_out <= ~idx;
		req_subidx_out <= ~sub;
		req_wdata_out <= ~wd;
		#1;
		while (rsp_valid_in !== 1'b1 && n < 4) begin
			@(posedge mclk_in);
			#1;
			n++;
		end
		rd = rsp_data_in;
		ab = (rsp_valid_in === 1'b1) ? rsp_abort_in : 1'bx;
	endtask
endmodule

// *** test/canopen_comm_profile_dictionary_tb.sv ***
// Self-checking bench for the communication-profile dictionary
`timescale 1ns/1ns
module canopen_comm_profile_dictionary_tb;
	import comm_dict_pkg::*;
	localparam logic [3:0] CAPS = 4'h5;
	// Arbitrary vendor code
	localparam logic [31:0] VEND = 32'h1234_5678;
	localparam logic [31:0] STRS [3] = '{32'h4142_4344, 32'h3130_3041, 32'h3230_3042};
	localparam logic [15:0] SIDX [3] = '{IDX_NAME, IDX_HWVER, IDX_SWVER};
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [6:0] node_id = 7'h01;
	logic [7:0] err_reg = 8'h00;
	logic push = 1'b0;
	logic [31:0] code = 32'h0000_0000;
	logic emcy_req = 1'b0;
	logic rx_valid = 1'b0;
	logic [10:0] rx_id = 11'h000;
	logic req_valid, req_write, rsp_valid, rsp_abort, emcy_send, sync_seen, store_cmd, restore_cmd;
	logic [15:0] req_index, guard;
	logic [7:0] req_subidx, life;
	logic [31:0] req_wdata, rsp_data, sync_id, emcy_id, rd, v;
	logic [1:0] store_group;
	logic ab;
	logic [31:0] hist [$];
	int fails = 0;
	int checks_done = 0;
	int gap;

	comm_dictionary #(.IO_CAPS(CAPS), .NAME_STR(STRS[0]), .HW_VER_STR(STRS[1]), .SW_VER_STR(STRS[2]),
		.VENDOR_CODE(VEND), .CYC_PER_MS(4)) dut (.mclk_in(mclk_in), .rst_in(rst_in), .node_id_in(node_id),
		.req_valid_in(req_valid), .req_write_in(req_write), .req_index_in(req_index), .req_subidx_in(req_subidx),
		.req_wdata_in(req_wdata), .rsp_valid_out(rsp_valid), .rsp_abort_out(rsp_abort), .rsp_data_out(rsp_data),
		.error_reg_in(err_reg), .err_push_in(push), .err_code_in(code), .emcy_req_in(emcy_req),
		.emcy_send_out(emcy_send), .rx_valid_in(rx_valid), .rx_id_in(rx_id), .sync_seen_out(sync_seen),
		.store_cmd_out(store_cmd), .restore_cmd_out(restore_cmd), .store_group_out(store_group),
		.sync_id_out(sync_id), .emcy_id_out(emcy_id), .guard_time_out(guard), .life_factor_out(life));

	sdo_client_model cl (.mclk_in(mclk_in), .req_valid_out(req_valid), .req_write_out(req_write),
		.req_index_out(req_index), .req_subidx_out(req_subidx), .req_wdata_out(req_wdata),
		.rsp_valid_in(rsp_valid), .rsp_abort_in(rsp_abort), .rsp_data_in(rsp_data));

	// Free-running 20 MHz clock
	initial begin
		forever #25 mclk_in = ~mclk_in;
	end

	// Expected device type word from the capability flags
	function automatic logic [31:0] devtype_exp(input logic [3:0] caps);
		return {8'h00, 4'h0, caps, 16'h0191};
	endfunction

	// Expected SYNC entry: only the 11-bit identifier survives
	function automatic logic [31:0] sync_exp(input logic [31:0] w);
		return {21'h00_0000, w[10:0]};
	endfunction

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		chk32({31'h0, got}, {31'h0, exp});
	endtask

	task automatic rd_chk(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
		cl.xfer(1'b0, idx, sub, 32'h0000_0000, rd, ab);
		chk1(ab, 1'b0);
		chk32(rd, exp);
	endtask

	task automatic ab_chk(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] c);
		cl.xfer(wr, idx, sub, 32'h5a5a_0001, rd, ab);
		chk1(ab, 1'b1);
		chk32(rd, c);
	endtask

	task automatic wr_ok(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd);
		cl.xfer(1'b1, idx, sub, wd, rd, ab);
		chk1(ab, 1'b0);
		chk32(rd, 32'h0000_0000);
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge mclk_in);
		fails++;
		end_sim;
	end

	initial begin
		v = $urandom(32'hdda4_3e71);
		node_id = 7'($urandom_range(1, 127));
		err_reg = 8'($urandom);
		repeat (16) @(posedge mclk_in);
		rst_in <= 1'b0;
		// Reset values and empty history
		chk32(sync_id, 32'h0000_0080);
		chk32(emcy_id, 32'h0000_0080 + node_id);
		chk32({16'h0, guard}, 32'h0000_0000);
		rd_chk(IDX_SYNC, 8'h00, 32'h0000_0080);
		rd_chk(IDX_EMCY, 8'h00, 32'h0000_0080 + node_id);
		rd_chk(IDX_ERRHIST, 8'h00, 32'h0000_0000);
		ab_chk(1'b0, IDX_ERRHIST, 8'h01, ABORT_NO_SUB);
		$display("test reset done");
		// Read-only identification entries
		rd_chk(IDX_DEVTYPE, 8'h00, devtype_exp(CAPS));
		ab_chk(1'b1, IDX_DEVTYPE, 8'h00, ABORT_READ_ONLY);
		rd_chk(IDX_ERRREG, 8'h00, {24'h0, err_reg});
		for (int i = 0; i < 3; i++) begin
			rd_chk(SIDX[i], 8'h00, STRS[i]);
			ab_chk(1'b1, SIDX[i], 8'h00, ABORT_READ_ONLY);
		end
		rd_chk(IDX_IDENT, 8'h00, 32'h0000_0001);
		rd_chk(IDX_IDENT, 8'h01, VEND);
		ab_chk(1'b0, IDX_IDENT, 8'h02, ABORT_NO_SUB);
		rd_chk(IDX_SDO, 8'h00, 32'h0000_0002);
		rd_chk(IDX_SDO, 8'h01, 32'h0000_0600 + node_id);
		rd_chk(IDX_SDO, 8'h02, 32'h0000_0580 + node_id);
		ab_chk(1'b1, IDX_SDO, 8'h01, ABORT_READ_ONLY);
		ab_chk(1'b0, 16'h1002, 8'h00, ABORT_NO_OBJ);
		ab_chk(1'b0, IDX_SYNC, 8'h01, ABORT_NO_SUB);
		$display("test read-only entries done");
		// SYNC identifier with random upper bits and frame matching
		for (int i = 0; i < 4; i++) begin
			v = $urandom;
			wr_ok(IDX_SYNC, 8'h00, v);
			rd_chk(IDX_SYNC, 8'h00, sync_exp(v));
			chk32(sync_id, sync_exp(v));
			for (int m = 0; m < 2; m++) begin
				@(posedge mclk_in);
				rx_valid <= 1'b1;
				rx_id <= v[10:0] ^ 11'(m);
				@(posedge mclk_in);
				rx_valid <= 1'b0;
				#1;
				chk1(sync_seen, m == 0);
			end
		end
		$display("test sync done");
		// Range limits of guard and inhibit times, boundary and random
		for (int i = 0; i < 2; i++) begin
			wr_ok(i ? IDX_INHIBIT : IDX_GUARD, 8'h00, 32'h0000_7fff);
			ab_chk(1'b1, i ? IDX_INHIBIT : IDX_GUARD, 8'h00, ABORT_RANGE);
			rd_chk(i ? IDX_INHIBIT : IDX_GUARD, 8'h00, 32'h0000_7fff);
			v = $urandom_range(0, 32767);
			wr_ok(i ? IDX_INHIBIT : IDX_GUARD, 8'h00, v);
			rd_chk(i ? IDX_INHIBIT : IDX_GUARD, 8'h00, v);
			if (i == 0) begin
				chk32({16'h0, guard}, v);
			end
		end
		v = {24'h0, 8'($urandom)};
		wr_ok(IDX_LIFE, 8'h00, v);
		rd_chk(IDX_LIFE, 8'h00, v);
		chk32({24'h0, life}, v);
		$display("test ranges done");
		// Store and restore commands for every group
		for (int i = 1; i <= 3; i++) begin
			for (int s = 0; s < 2; s++) begin
				cl.xfer(1'b1, s ? IDX_RESTORE : IDX_STORE, 8'(i), $urandom, rd, ab);
				chk1(ab, 1'b0);
				chk1(store_cmd, s == 0);
				chk1(restore_cmd, s == 1);
				chk32({30'h0, store_group}, i);
				rd_chk(s ? IDX_RESTORE : IDX_STORE, 8'(i), STORE_CAPS);
			end
		end
		rd_chk(IDX_STORE, 8'h00, 32'h0000_0003);
		ab_chk(1'b1, IDX_RESTORE, 8'h00, ABORT_READ_ONLY);
		ab_chk(1'b1, IDX_STORE, 8'h04, ABORT_NO_SUB);
		$display("test store done");
		// Six pushes overflow the five-deep history
		for (int i = 0; i < 6; i++) begin
			v = $urandom;
			hist.push_front(v);
			@(posedge mclk_in);
			push <= 1'b1;
			code <= v;
			@(posedge mclk_in);
			push <= 1'b0;
		end
		rd_chk(IDX_ERRHIST, 8'h00, 32'h0000_0005);
		for (int k = 1; k <= 5; k++) begin
			rd_chk(IDX_ERRHIST, 8'(k), hist[k - 1]);
		end
		ab_chk(1'b0, IDX_ERRHIST, 8'h06, ABORT_NO_SUB);
		ab_chk(1'b1, IDX_ERRHIST, 8'h01, ABORT_READ_ONLY);
		$display("test history done");
		// Emergency identifier and pacing at 3 ms of 4 cycles each
		v = $urandom;
		wr_ok(IDX_EMCY, 8'h00, v);
		rd_chk(IDX_EMCY, 8'h00, v);
		chk32(emcy_id, v);
		// Zero inhibit: the request passes for as long as it is held
		wr_ok(IDX_INHIBIT, 8'h00, 32'h0000_0000);
		@(posedge mclk_in);
		emcy_req <= 1'b1;
		repeat (2) @(posedge mclk_in);
		#1;
		chk1(emcy_send, 1'b1);
		@(posedge mclk_in);
		emcy_req <= 1'b0;
		wr_ok(IDX_INHIBIT, 8'h00, 32'h0000_0003);
		@(posedge mclk_in);
		emcy_req <= 1'b1;
		#1;
		chk1(emcy_send, 1'b1);
		gap = 0;
		do begin
			@(posedge mclk_in);
			#1;
			gap++;
		end while (emcy_send !== 1'b1 && gap < 40);
		chk1(gap >= 12 && gap <= 14, 1'b1);
		@(posedge mclk_in);
		emcy_req <= 1'b0;
		$display("test emergency done");
		end_sim;
	end
endmodule
